/* File: fci_defines.vh */
// constants shared by the flash image checksum engine
// assumes inclusion by bare name from each design file
`ifndef FCI_DEFINES_VH
`define FCI_DEFINES_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define FCI_SUM_W 32
`define FCI_WORD_W 32
`define FCI_BYTE_W 8
`define FCI_FOLD_W 10
`define FCI_FAM_W 2
`define FCI_KIND_W 4

// ----------------------------------------------------------------
// family codes
// ----------------------------------------------------------------
`define FCI_FAM_LEGACY 2'h0
`define FCI_FAM_MOTOR 2'h1
`define FCI_FAM_PANEL 2'h2
`define FCI_FAM_PANEL_OLD 2'h3

// ----------------------------------------------------------------
// register word kinds
// ----------------------------------------------------------------
`define FCI_KIND_CFG0 4'h0
`define FCI_KIND_CFG4 4'h4
`define FCI_KIND_IDENT 4'h5
`define FCI_KIND_PROTECT 4'h6
`define FCI_KIND_USER 4'h7
`define FCI_KIND_BOOTCFG 4'h8
`define FCI_LAST_CFG_OLD 4'h3
`define FCI_LAST_CFG_NEW 4'h4

// ----------------------------------------------------------------
// fixed masks
// ----------------------------------------------------------------
`define FCI_PROTECT_MASK 32'h10000000
`define FCI_USER_MASK 32'h00000FFF
`define FCI_BOOTCFG_MASK 32'h8000000B
`define FCI_ZERO_MASK 32'h00000000

// ----------------------------------------------------------------
// excluded boot flash pages
// ----------------------------------------------------------------
`define FCI_PANEL_TOP 12'h1FC
`define FCI_PANEL_PAGE 8'hFF
`define FCI_MOTOR_PAGE 24'h1FC03F
`define FCI_ADDR_MSB 31
`define FCI_TOP_LSB 20
`define FCI_PAGE_MSB 15
`define FCI_PAGE_LSB 8

// ----------------------------------------------------------------
// results and reset values
// ----------------------------------------------------------------
`define FCI_SUM_RESET 32'h00000000
`define FCI_CHECKSUM_CP 32'h00000000
`define FCI_ONE 32'h00000001

`endif

/* File: fci_word_fold.v */
// masks one 32-bit register word and folds its four bytes into a sum
// assumes the caller gates valid with its own acceptance condition
`timescale 1ns/1ps
`include "fci_defines.vh"

module fci_word_fold (
  input wire core_clk_i,                   // system clock
  input wire reset_n_i,                    // async reset, active low
  input wire clk_en_i,                     // freezes state while low
  input wire valid_i,                      // word present
  input wire [`FCI_WORD_W-1:0] word_i,     // raw word
  input wire [`FCI_WORD_W-1:0] mask_i,     // mask applied first
  output reg valid_o,                      // folded sum present
  output reg [`FCI_FOLD_W-1:0] sum_o       // sum of masked bytes
);

  wire [`FCI_WORD_W-1:0] masked;
  wire [`FCI_FOLD_W-1:0] part [0:4];

  assign masked = word_i & mask_i;
  assign part[0] = {`FCI_FOLD_W{1'b0}};

  genvar b;
  generate
    for (b = 0; b < `FCI_WORD_W/`FCI_BYTE_W; b = b + 1)
    begin : g_byte
      assign part[b+1] = part[b]
                       + {{(`FCI_FOLD_W-`FCI_BYTE_W){1'b0}}, masked[b*`FCI_BYTE_W +: `FCI_BYTE_W]};
    end
  endgenerate

  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      valid_o <= 1'b0;
      sum_o <= {`FCI_FOLD_W{1'b0}};
    end
    else if (clk_en_i)
    begin
      valid_o <= valid_i;
      sum_o <= valid_i ? part[4] : {`FCI_FOLD_W{1'b0}};
    end
  end

endmodule // fci_word_fold

/* File: fci_boot_filter.v */
// sorts flash bytes into program and boot streams, dropping reserved boot pages
// assumes the caller gates valid with its own acceptance condition
`timescale 1ns/1ps
`include "fci_defines.vh"

module fci_boot_filter (
  input wire core_clk_i,                   // system clock
  input wire reset_n_i,                    // async reset, active low
  input wire clk_en_i,                     // freezes state while low
  input wire valid_i,                      // byte present
  input wire boot_i,                       // byte is from boot flash
  input wire [31:0] addr_i,                // physical byte address
  input wire [`FCI_BYTE_W-1:0] data_i,     // byte value
  input wire [`FCI_FAM_W-1:0] family_i,    // family select
  output reg prog_valid_o,                 // program byte to add
  output reg boot_valid_o,                 // boot byte to add
  output reg [`FCI_BYTE_W-1:0] data_o      // byte to add
);

  wire panel_fam;
  wire panel_hit;
  wire motor_hit;
  wire skip;

  assign panel_fam = (family_i == `FCI_FAM_PANEL) || (family_i == `FCI_FAM_PANEL_OLD);
  assign panel_hit = (addr_i[`FCI_ADDR_MSB:`FCI_TOP_LSB] == `FCI_PANEL_TOP)
                  && (addr_i[`FCI_PAGE_MSB:`FCI_PAGE_LSB] == `FCI_PANEL_PAGE);
  assign motor_hit = (addr_i[`FCI_ADDR_MSB:`FCI_PAGE_LSB] == `FCI_MOTOR_PAGE);
  assign skip = (panel_fam && panel_hit)
             || ((family_i == `FCI_FAM_MOTOR) && motor_hit);

  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prog_valid_o <= 1'b0;
      boot_valid_o <= 1'b0;
      data_o <= {`FCI_BYTE_W{1'b0}};
    end
    else if (clk_en_i)
    begin
      prog_valid_o <= valid_i && !boot_i;
      boot_valid_o <= valid_i && boot_i && !skip;
      data_o <= data_i;
    end
  end

endmodule // fci_boot_filter

/* File: fci_checksum.v */
// flash image checksum engine: byte and register-word streams in, checksum out
// assumes a reader on the same clock that streams bytes and words between start and finish
`timescale 1ns/1ps
`include "fci_defines.vh"

// Behaviour
// - keep a 32-bit sum of program, boot, masked ident and config bytes
// - final checksum is the inverted sum plus one
// - each config word is ANDed with its mask before its bytes add
// - ident word is ANDed with its mask before its bytes add
// - config words 0..3 for older families, 0..4 for the newer one
// - dual-panel families drop boot bytes at 0x1FCxFF00..0x1FCxFFFF
// - motor-control family drops boot bytes 0x1FC03F00..0x1FC03FFF
// - motor-control family also adds protect word masked with 0x10000000
// - dual-boot families sum only primary config word copies
// - dual-panel user ident mask 0x0000FFF, boot config mask 0x8000000B
// - while code-protected the reported checksum is zero
module fci_checksum (
  input wire core_clk_i,                       // 20 MHz system clock
  input wire reset_n_i,                        // async reset, active low
  input wire clk_en_i,                         // freezes all state while low
  input wire [`FCI_FAM_W-1:0] family_i,        // family select, held during a run
  input wire code_protect_i,                   // device is code-protected
  input wire start_i,                          // pulse: begin a run
  input wire finish_i,                         // pulse: last data this cycle
  input wire byte_valid_i,                     // flash byte present
  input wire byte_boot_i,                      // byte belongs to boot flash
  input wire [31:0] byte_addr_i,               // physical byte address
  input wire [`FCI_BYTE_W-1:0] byte_data_i,    // flash byte
  input wire word_valid_i,                     // register word present
  input wire [`FCI_KIND_W-1:0] word_kind_i,    // which register word
  input wire word_primary_i,                   // word is the primary copy
  input wire [`FCI_WORD_W-1:0] config_word_i,  // raw register word value
  input wire [`FCI_WORD_W-1:0] word_mask_i,    // family mask for config and ident
  output reg busy_o,                           // run in progress
  output reg checksum_valid_o,                 // pulse: checksum updated
  output reg [`FCI_SUM_W-1:0] checksum_o,      // final checksum
  output reg [`FCI_SUM_W-1:0] program_area_sum_o, // running program byte sum
  output reg [`FCI_SUM_W-1:0] boot_area_sum_o, // running boot byte sum
  output reg [`FCI_SUM_W-1:0] config_term_sum_o // running masked word sum
);

  // ----------------------------------------------------------------
  // state encoding
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_FINAL = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg finish_q;

  wire accept;
  wire [`FCI_SUM_W-1:0] total;

  // ----------------------------------------------------------------
  // acceptance window
  // ----------------------------------------------------------------
  // data is taken on the start cycle and in run until finish is seen
  assign accept = start_i || ((state == ST_RUN) && !finish_q);

  // ----------------------------------------------------------------
  // register word selection and masking
  // ----------------------------------------------------------------
  reg word_take;
  reg [`FCI_WORD_W-1:0] word_mask;
  wire panel_fam;
  wire dual_boot;
  wire [`FCI_KIND_W-1:0] last_cfg;

  assign panel_fam = (family_i == `FCI_FAM_PANEL) || (family_i == `FCI_FAM_PANEL_OLD);
  assign dual_boot = panel_fam || (family_i == `FCI_FAM_MOTOR);
  assign last_cfg = (family_i == `FCI_FAM_PANEL) ? `FCI_LAST_CFG_NEW
                                                 : `FCI_LAST_CFG_OLD;

  always @*
  begin
    word_take = 1'b0;
    word_mask = `FCI_ZERO_MASK;
    if (word_kind_i <= `FCI_KIND_CFG4)
    begin
      // config words: range by family, primary copy only in dual-boot families
      word_take = (word_kind_i <= last_cfg)
               && (word_primary_i || !dual_boot);
      word_mask = word_mask_i;
    end
    else
    begin
      case (word_kind_i)
        `FCI_KIND_IDENT:
        begin
          word_take = 1'b1;
          word_mask = word_mask_i;
        end
        `FCI_KIND_PROTECT:
        begin
          word_take = (family_i == `FCI_FAM_MOTOR);
          word_mask = `FCI_PROTECT_MASK;
        end
        `FCI_KIND_USER:
        begin
          word_take = panel_fam && word_primary_i;
          word_mask = `FCI_USER_MASK;
        end
        `FCI_KIND_BOOTCFG:
        begin
          word_take = panel_fam && word_primary_i;
          word_mask = `FCI_BOOTCFG_MASK;
        end
        default:
        begin
          word_take = 1'b0;
          word_mask = `FCI_ZERO_MASK;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // first pipeline stage
  // ----------------------------------------------------------------
  wire fold_valid;
  wire [`FCI_FOLD_W-1:0] fold_sum;
  wire prog_valid;
  wire boot_valid;
  wire [`FCI_BYTE_W-1:0] flash_byte;

  fci_word_fold u_fold (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .valid_i(word_valid_i && word_take && accept),
    .word_i(config_word_i),
    .mask_i(word_mask),
    .valid_o(fold_valid),
    .sum_o(fold_sum)
  );

  fci_boot_filter u_filter (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .valid_i(byte_valid_i && accept),
    .boot_i(byte_boot_i),
    .addr_i(byte_addr_i),
    .data_i(byte_data_i),
    .family_i(family_i),
    .prog_valid_o(prog_valid),
    .boot_valid_o(boot_valid),
    .data_o(flash_byte)
  );

  // ----------------------------------------------------------------
  // control state machine
  // ----------------------------------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (start_i)
          next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (start_i)
          next_state = ST_RUN;
        else if (finish_q)
          next_state = ST_FINAL;
      end
      ST_FINAL:
      begin
        if (start_i)
          next_state = ST_RUN;
        else
          next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state <= ST_IDLE;
      finish_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state <= next_state;
      finish_q <= finish_i && accept && !start_i;
    end
  end

  // busy follows the state that is being entered
  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      busy_o <= 1'b0;
    else if (clk_en_i)
      busy_o <= (next_state != ST_IDLE);
  end

  // ----------------------------------------------------------------
  // accumulators
  // ----------------------------------------------------------------
  // stage results arrive one cycle after acceptance and add while running
  wire add_en;
  wire [`FCI_SUM_W-1:0] byte_add;
  wire [`FCI_SUM_W-1:0] cfg_add;

  // a start in the same cycle wins over a pending stage result
  assign add_en = (state == ST_RUN) && !start_i;
  assign byte_add = {{(`FCI_SUM_W-`FCI_BYTE_W){1'b0}}, flash_byte};
  assign cfg_add = {{(`FCI_SUM_W-`FCI_FOLD_W){1'b0}}, fold_sum};

  // program flash bytes
  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      program_area_sum_o <= `FCI_SUM_RESET;
    else if (clk_en_i)
    begin
      if (start_i)
        program_area_sum_o <= `FCI_SUM_RESET;
      else if (add_en && prog_valid)
        program_area_sum_o <= program_area_sum_o + byte_add;
    end
  end

  // boot flash bytes that survived the page filter
  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      boot_area_sum_o <= `FCI_SUM_RESET;
    else if (clk_en_i)
    begin
      if (start_i)
        boot_area_sum_o <= `FCI_SUM_RESET;
      else if (add_en && boot_valid)
        boot_area_sum_o <= boot_area_sum_o + byte_add;
    end
  end

  // folded register words
  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      config_term_sum_o <= `FCI_SUM_RESET;
    else if (clk_en_i)
    begin
      if (start_i)
        config_term_sum_o <= `FCI_SUM_RESET;
      else if (add_en && fold_valid)
        config_term_sum_o <= config_term_sum_o + cfg_add;
    end
  end

  // ----------------------------------------------------------------
  // final result
  // ----------------------------------------------------------------
  // three-way add wraps at 32 bits
  assign total = program_area_sum_o + boot_area_sum_o + config_term_sum_o;

  // one-cycle pulse for the single final cycle of a run
  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      checksum_valid_o <= 1'b0;
    else if (clk_en_i)
      checksum_valid_o <= (state == ST_FINAL);
  end

  // result holds until the next run reaches its final cycle
  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      checksum_o <= `FCI_SUM_RESET;
    else if (clk_en_i && (state == ST_FINAL))
    begin
      if (code_protect_i)
        checksum_o <= `FCI_CHECKSUM_CP;
      else
        checksum_o <= ~total + `FCI_ONE;
    end
  end

endmodule // fci_checksum

/* File: fci_checksum_monitor.sv */
// checker for the flash image checksum engine, bound to fci_checksum
// assumes clk_en_i held high and no items sent after finish
`timescale 1ns/1ps
`include "fci_defines.vh"
module fci_checksum_monitor (
  input wire core_clk_i, // clock
  input wire reset_n_i, // reset, active low
  input wire [`FCI_FAM_W-1:0] family_i, // family
  input wire code_protect_i, // protect level
  input wire start_i, // run start
  input wire finish_i, // last item
  input wire byte_valid_i, // byte present
  input wire byte_boot_i, // boot byte
  input wire [31:0] byte_addr_i, // byte address
  input wire [`FCI_BYTE_W-1:0] byte_data_i, // byte value
  input wire busy_o, // run active
  input wire checksum_valid_o, // result pulse
  input wire [`FCI_SUM_W-1:0] checksum_o, // result
  input wire [`FCI_SUM_W-1:0] program_area_sum_o, // program sum
  input wire [`FCI_SUM_W-1:0] boot_area_sum_o, // boot sum
  input wire [`FCI_SUM_W-1:0] config_term_sum_o // word sum
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire [31:0] total = program_area_sum_o + boot_area_sum_o + config_term_sum_o;
  wire excl = (family_i == `FCI_FAM_MOTOR && byte_addr_i[31:8] == `FCI_MOTOR_PAGE) ||
    (family_i[1] && byte_addr_i[31:20] == `FCI_PANEL_TOP && byte_addr_i[15:8] == `FCI_PANEL_PAGE);
  sequence fin_s;
    finish_i && busy_o && !start_i ##1 !start_i [*3];
  endsequence
  sequence prog_s;
    byte_valid_i && !byte_boot_i && busy_o && !start_i ##1 !start_i;
  endsequence
  sequence drop_s;
    byte_valid_i && byte_boot_i && excl && busy_o && !start_i ##1 !start_i;
  endsequence
  done_pulse_a: assert property (fin_s |-> ##[0:1] checksum_valid_o)
    else $error("no checksum pulse after finish");
  pulse_single_a: assert property (checksum_valid_o |=> !checksum_valid_o)
    else $error("checksum pulse too long");
  busy_start_a: assert property (start_i |=> busy_o)
    else $error("busy missing after start");
  checksum_math_a: assert property (checksum_valid_o && !code_protect_i |->
    checksum_o == ~total + `FCI_ONE)
    else $error("checksum not two's complement of sum");
  protect_zero_a: assert property (checksum_valid_o && code_protect_i |-> checksum_o == 0)
    else $error("protected checksum not zero");
  checksum_hold_a: assert property (!checksum_valid_o |-> $stable(checksum_o))
    else $error("checksum changed without pulse");
  busy_clear_a: assert property (checksum_valid_o |-> !busy_o)
    else $error("busy high with result");
  prog_add_a: assert property (prog_s |=>
    program_area_sum_o == $past(program_area_sum_o) + $past(byte_data_i, 2))
    else $error("program byte not added");
  boot_exclude_a: assert property (drop_s |=> $stable(boot_area_sum_o))
    else $error("excluded boot byte added");
endmodule // fci_checksum_monitor

/* File: fci_reader_model.sv */
// memory reader model feeding flash bytes and register words
// assumes the bench calls drive just after a rising clock edge
`timescale 1ns/1ps
module fci_reader_model (
  output logic byte_valid_o, // byte present
  output logic byte_boot_o, // boot flash byte
  output logic [31:0] byte_addr_o, // byte address
  output logic [7:0] byte_data_o, // byte value
  output logic word_valid_o, // word present
  output logic [3:0] word_kind_o, // word kind
  output logic word_primary_o, // primary copy
  output logic [31:0] word_o, // raw word
  output logic [31:0] mask_o // word mask
);
  initial {byte_valid_o, byte_boot_o, byte_addr_o, byte_data_o, word_valid_o,
    word_kind_o, word_primary_o, word_o, mask_o} = '0;
  // released lines show the inverse of the last value
  task automatic drive(input logic bv, input logic bb, input logic [31:0] ba,
    input logic [7:0] bd, input logic wv, input logic [3:0] wk, input logic wp,
    input logic [31:0] wd, input logic [31:0] wm);
    byte_valid_o <= bv;
    byte_boot_o <= bv ? bb : ~byte_boot_o;
    byte_addr_o <= bv ? ba : ~byte_addr_o;
    byte_data_o <= bv ? bd : ~byte_data_o;
    word_valid_o <= wv;
    word_kind_o <= wv ? wk : ~word_kind_o;
    word_primary_o <= wv ? wp : ~word_primary_o;
    word_o <= wv ? wd : ~word_o;
    mask_o <= wv ? wm : ~mask_o;
  endtask
endmodule // fci_reader_model

/* File: tb_fci_checksum.sv */
// self-checking bench for the flash image checksum engine
// assumes fci_reader_model as the byte and word source
`timescale 1ns/1ps
`include "fci_defines.vh"
module tb_fci_checksum;
  logic core_clk_i = 0;
  logic reset_n_i = 0;
  logic clk_en_i = 1;
  logic [1:0] family_i = 0;
  logic code_protect_i = 0;
  logic start_i = 0;
  logic finish_i = 0;
  wire bv, bb, wv, wp, busy_o, checksum_valid_o;
  wire [31:0] ba, wd, wm, checksum_o, program_area_sum_o, boot_area_sum_o, config_term_sum_o;
  wire [7:0] bd;
  wire [3:0] wk;
  int miscompares = 0;
  int comparisons = 0;
  logic [31:0] exp_sum;
  logic [31:0] exp_prog;
  logic [31:0] exp_boot;
  logic [31:0] exp_cfg;
  logic [31:0] corner [0:5] = '{32'h1FC03F00, 32'h1FC03FFF, 32'h1FC03EFF, 32'h1FC1FF00,
    32'h1FC1FFFF, 32'h1FC1FEFF};
  always #25 core_clk_i = ~core_clk_i;
  fci_reader_model fci_reader_model_inst (.byte_valid_o(bv), .byte_boot_o(bb),
    .byte_addr_o(ba), .byte_data_o(bd), .word_valid_o(wv), .word_kind_o(wk),
    .word_primary_o(wp), .word_o(wd), .mask_o(wm));
  fci_checksum fci_checksum_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i), .family_i(family_i), .code_protect_i(code_protect_i),
    .start_i(start_i), .finish_i(finish_i), .byte_valid_i(bv), .byte_boot_i(bb),
    .byte_addr_i(ba), .byte_data_i(bd), .word_valid_i(wv), .word_kind_i(wk),
    .word_primary_i(wp), .config_word_i(wd), .word_mask_i(wm), .busy_o(busy_o),
    .checksum_valid_o(checksum_valid_o), .checksum_o(checksum_o),
    .program_area_sum_o(program_area_sum_o), .boot_area_sum_o(boot_area_sum_o),
    .config_term_sum_o(config_term_sum_o));
  // ------------------------------------------------------------
  // expectation helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] fold(input logic [31:0] w, input logic [31:0] m);
    logic [31:0] x;
    x = w & m;
    return x[7:0] + x[15:8] + x[23:16] + x[31:24];
  endfunction
  function automatic logic [31:0] pick_mask(input logic [1:0] f, input logic [3:0] k,
    input logic p, input logic [31:0] m);
    if (f != 0 && !p && (k < 5 || k > 6)) return 32'h0;
    if (k < 4 || k == 5 || (k == 4 && f == 2)) return m;
    if (k == 6 && f == 1) return 32'h10000000;
    if (k == 7 && f[1]) return 32'h00000FFF;
    if (k == 8 && f[1]) return 32'h8000000B;
    return 32'h0;
  endfunction
  function automatic bit excluded(input logic [1:0] f, input logic [31:0] a);
    return (f == 1 && a[31:8] == 24'h1FC03F) || (f[1] && a[31:20] == 12'h1FC && a[15:8] == 8'hFF);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one random item per cycle, bytes and words may coincide
  task automatic item(input logic [1:0] f);
    logic [31:0] a, w, m;
    logic [7:0] d;
    logic [3:0] k;
    logic p;
    int c;
    c = $urandom_range(0, 3);
    a = $urandom_range(0, 1) ? corner[$urandom_range(0, 5)] : $urandom;
    d = $urandom;
    w = $urandom;
    m = $urandom;
    k = $urandom_range(0, 9);
    p = $urandom_range(0, 1);
    fci_reader_model_inst.drive(c != 0, c == 2, a, d, c == 3, k, p, w, m);
    if (c != 0 && !(c == 2 && excluded(f, a))) exp_sum += d;
    if (c == 2 && !excluded(f, a)) exp_boot += d;
    if (c == 1 || c == 3) exp_prog += d;
    if (c == 3) exp_sum += fold(w, pick_mask(f, k, p, m));
    if (c == 3) exp_cfg += fold(w, pick_mask(f, k, p, m));
  endtask
  task automatic run(input logic [1:0] f, input logic cp, input int n, input bit ab);
    int k;
    @(posedge core_clk_i);
    family_i <= f;
    code_protect_i <= cp;
    start_i <= 1;
    exp_sum = 0;
    exp_prog = 0;
    exp_boot = 0;
    exp_cfg = 0;
    item(f);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk_i);
      start_i <= ab && i == n / 2;
      if (ab && i == n / 2)
      begin
        exp_sum = 0;
        exp_prog = 0;
        exp_boot = 0;
        exp_cfg = 0;
      end
      finish_i <= i == n - 1;
      item(f);
    end
    @(posedge core_clk_i);
    finish_i <= 0;
    start_i <= 0;
    fci_reader_model_inst.drive(0, 0, 0, 0, 0, 0, 0, 0, 0);
    k = 0;
    while (checksum_valid_o !== 1'b1 && k < 8)
    begin
      @(posedge core_clk_i);
      #1;
      k++;
    end
    chk({31'h0, checksum_valid_o}, 32'h1);
    chk(checksum_o, cp ? 32'h0 : ~exp_sum + 32'h1);
    chk(program_area_sum_o, exp_prog);
    chk(boot_area_sum_o, exp_boot);
    chk(config_term_sum_o, exp_cfg);
    $display("test done family %0d protect %0d abort %0d", f, cp, ab);
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    void'($urandom(94));
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1;
    run(0, 0, 1, 0);
    for (int t = 0; t < 28; t++)
      run(t % 4, t % 7 == 3, $urandom_range(4, 40), t % 5 == 2);
    results();
  end
  initial
  begin
    #(50 * 5000);
    miscompares++;
    results();
  end
endmodule // tb_fci_checksum
bind fci_checksum fci_checksum_monitor fci_checksum_monitor_inst (.core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i), .family_i(family_i), .code_protect_i(code_protect_i),
  .start_i(start_i), .finish_i(finish_i), .byte_valid_i(byte_valid_i),
  .byte_boot_i(byte_boot_i), .byte_addr_i(byte_addr_i), .byte_data_i(byte_data_i),
  .busy_o(busy_o), .checksum_valid_o(checksum_valid_o), .checksum_o(checksum_o),
  .program_area_sum_o(program_area_sum_o), .boot_area_sum_o(boot_area_sum_o),
  .config_term_sum_o(config_term_sum_o));
